// [logic/rscs_pkg.sv]
// Package for the reset strap configuration select block
package rscs_pkg;

    // Strap pins with fixed meaning
    localparam int PROTO_PIN = 9;
    localparam int HOLD_PIN  = 8;

    // Default select pins when none are assigned
    localparam logic [15:0] DEF_SEL_MASK = 16'h000f;
    localparam int          IDX_MIN_W    = 4;
    localparam int          MAX_CFG      = 16;

    // Reset values of straps and derived settings
    localparam logic RST_I2C      = 1'h1;
    localparam logic RST_EE_DIS   = 1'h0;
    localparam logic RST_ADDR_BIT = 1'h0;
    localparam logic RST_CLK_EN   = 1'h0;
    localparam logic RST_GPIO_OUT = 1'h0;

    // Host write field codes
    localparam logic [2:0] FLD_PROTO  = 3'h0;
    localparam logic [2:0] FLD_INDEX  = 3'h1;
    localparam logic [2:0] FLD_EE_DIS = 3'h2;
    localparam logic [2:0] FLD_ADDR   = 3'h3;
    localparam logic [2:0] FLD_CLK_EN = 3'h4;
    localparam logic [2:0] FLD_GPIO   = 3'h5;

    localparam int HOST_DATA_W = 16;

    // Start-up sequencer states
    typedef enum logic [6:0] {
        ST_HOLD = 7'h01,
        ST_CAPT = 7'h02,
        ST_LOAD = 7'h04,
        ST_CHK  = 7'h08,
        ST_CAL  = 7'h10,
        ST_LOCK = 7'h20,
        ST_RUN  = 7'h40
    } rscs_state_e;

    // Single-bit strap results
    typedef struct packed {
        logic i2c;
        logic ee_dis;
        logic addr_bit;
        logic hold_fault;
    } rscs_strap_s;

    // Host serial-port write of a derived setting
    typedef struct packed {
        logic                   valid;
        logic [2:0]             field;
        logic [HOST_DATA_W-1:0] data;
    } rscs_host_wr_s;

    // Status returned by the stored configuration loader and the PLL
    typedef struct packed {
        logic load_done;
        logic cksum_ok;
        logic cal_done;
        logic locked;
    } rscs_boot_sts_s;

endpackage

// [logic/rscs_strap_cfg.sv]
// Reset strap capture and start-up configuration sequencer
`timescale 1ns/1ps

// Notes on behaviour
// (R1) Capture all pins at master reset rise
// (R2) Pin 9 low SPI, high I2C
// (R3) Board holds pin 8 high in reset
// (R4) No select pins: use pins 3..0
// (R5) Undriven default pins give index 15
// (R6) Lowest assigned pin is index LSB
// (R7) Under four pins: upper index bits zero
// (R8) Over four pins widen the index
// (R9) Index ignored without user configurations
// (R10) EEPROM-disable high blocks EEPROM reads
// (R11) No disable pin: search for EEPROM
// (R12) Several disable pins are ORed
// (R13) Address bit from pin, else zero
// (R14) Several address pins: highest index wins
// (R15) Address strap no effect in SPI
// (R16) Strap-derived settings stay host writable
// (R17) Defaults: clocks off, pins inputs
// (R18) Load config, regulators, clocks, PLL lock; regulators and clocks come on before the load
// (R19) Bad checksum keeps register defaults
// (R20) At most sixteen stored configurations
// (R21) Captured straps held until next reset
module rscs_strap_cfg #(
    parameter int NUM_GPIO = 16,
    parameter int NUM_OUT  = 16
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    master_reset_low,
    input  wire logic [NUM_GPIO-1:0]     gpio_in,
    input  wire logic [NUM_GPIO-1:0]     sel_pin_mask,
    input  wire logic [NUM_GPIO-1:0]     ee_dis_pin_mask,
    input  wire logic [NUM_GPIO-1:0]     addr_pin_mask,
    input  wire logic                    otp_has_user_cfg,
    input  wire rscs_pkg::rscs_boot_sts_s boot_sts,
    input  wire rscs_pkg::rscs_host_wr_s  host_wr,
    output logic                         serial_is_i2c_r,
    output logic [NUM_GPIO-1:0]          cfg_index_r,
    output logic                         ee_search_en_r,
    output logic                         slave_addr_bit_two_r,
    output logic                         hold_fault_r,
    output logic                         otp_load_req_r,
    output logic                         regs_use_defaults_r,
    output logic [NUM_OUT-1:0]           clk_out_en_r,
    output logic [NUM_GPIO-1:0]          gpio_out_mode_r,
    output logic                         regulators_en_r,
    output logic                         int_clocks_en_r,
    output logic                         pll_cal_start_r,
    output logic                         pll_lock_en_r,
    output logic                         boot_done_r
);

    // Reset release through two flops
    logic rst_meta_r;
    logic rst_n_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_s    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s    <= rst_meta_r;
        end
    end

    // Packs the assigned pins, lowest pin into the LSB
    function automatic logic [NUM_GPIO-1:0] pack_sel(
        input logic [NUM_GPIO-1:0] pins,
        input logic [NUM_GPIO-1:0] mask
    );
        logic [NUM_GPIO-1:0] r;
        int                  k;
        r = '0;
        k = 0;
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (mask[i]) begin
                r[k] = pins[i];
                k    = k + 1;
            end
        end
        return r;
    endfunction

    // Value of the highest assigned pin, zero when none
    function automatic logic top_pin(
        input logic [NUM_GPIO-1:0] pins,
        input logic [NUM_GPIO-1:0] mask
    );
        logic v;
        v = 1'b0;
        for (int i = 0; i < NUM_GPIO; i++) begin
            if (mask[i]) begin
                v = pins[i];
            end
        end
        return v;
    endfunction

    // Master reset edge detection; input is synchronous
    logic mr_low_d_r;
    wire  mr_rise = master_reset_low & ~mr_low_d_r;
    wire  mr_fall = ~master_reset_low & mr_low_d_r;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            mr_low_d_r <= 1'b0;
        end else begin
            mr_low_d_r <= master_reset_low;
        end
    end

    // (R3) Pin 8 watch during reset
    logic hold_low_seen_r;
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            hold_low_seen_r <= 1'b0;
        end else if (mr_fall) begin
            hold_low_seen_r <= ~gpio_in[rscs_pkg::HOLD_PIN];
        end else if (!master_reset_low && !gpio_in[rscs_pkg::HOLD_PIN]) begin
            hold_low_seen_r <= 1'b1;
        end
    end

    // (R4) (R5) Default select pins when none assigned
    wire [NUM_GPIO-1:0] eff_sel_mask = (sel_pin_mask == '0)
                                     ? NUM_GPIO'(rscs_pkg::DEF_SEL_MASK)
                                     : sel_pin_mask;
    // (R6) Pack in pin order; (R7) (R8) width follows pin count
    wire [NUM_GPIO-1:0] sel_index    = pack_sel(gpio_in, eff_sel_mask);
    // (R12) Any disable pin high blocks EEPROM
    wire                ee_dis_pin   = |(gpio_in & ee_dis_pin_mask);
    // (R14) Highest assigned address pin only
    wire                addr_pin     = top_pin(gpio_in, addr_pin_mask);

    rscs_pkg::rscs_strap_s strap_nxt;
    always_comb begin
        // (R2) Protocol from pin 9
        strap_nxt.i2c        = gpio_in[rscs_pkg::PROTO_PIN];
        // (R10) (R11) Disable only when a pin says so
        strap_nxt.ee_dis     = ee_dis_pin;
        // (R13) (R15) Address bit only used for I2C
        strap_nxt.addr_bit   = gpio_in[rscs_pkg::PROTO_PIN] & addr_pin;
        strap_nxt.hold_fault = hold_low_seen_r | ~gpio_in[rscs_pkg::HOLD_PIN];
    end

    // Host write decode
    wire hw_proto = host_wr.valid && host_wr.field == rscs_pkg::FLD_PROTO;
    wire hw_index = host_wr.valid && host_wr.field == rscs_pkg::FLD_INDEX;
    wire hw_eedis = host_wr.valid && host_wr.field == rscs_pkg::FLD_EE_DIS;
    wire hw_addr  = host_wr.valid && host_wr.field == rscs_pkg::FLD_ADDR;
    wire hw_clken = host_wr.valid && host_wr.field == rscs_pkg::FLD_CLK_EN;
    wire hw_gpio  = host_wr.valid && host_wr.field == rscs_pkg::FLD_GPIO;
    wire [NUM_GPIO-1:0] hw_data_g = NUM_GPIO'(host_wr.data);
    wire [NUM_OUT-1:0]  hw_data_o = NUM_OUT'(host_wr.data);

    // (R1) Capture at rise; (R21) held otherwise; (R16) host may replace
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            serial_is_i2c_r      <= rscs_pkg::RST_I2C;
            cfg_index_r          <= '1;
            ee_search_en_r       <= ~rscs_pkg::RST_EE_DIS;
            slave_addr_bit_two_r <= rscs_pkg::RST_ADDR_BIT;
            hold_fault_r         <= 1'b0;
        end else if (mr_rise) begin
            serial_is_i2c_r      <= strap_nxt.i2c;
            cfg_index_r          <= sel_index;
            ee_search_en_r       <= ~strap_nxt.ee_dis;
            slave_addr_bit_two_r <= strap_nxt.addr_bit;
            hold_fault_r         <= strap_nxt.hold_fault;
        end else begin
            if (hw_proto) begin
                serial_is_i2c_r <= host_wr.data[0];
            end
            if (hw_index) begin
                cfg_index_r <= hw_data_g;
            end
            if (hw_eedis) begin
                ee_search_en_r <= ~host_wr.data[0];
            end
            if (hw_addr) begin
                slave_addr_bit_two_r <= host_wr.data[0];
            end
        end
    end

    // Start-up sequencer
    rscs_pkg::rscs_state_e state_r;
    rscs_pkg::rscs_state_e state_nxt;

    // (R9) (R20) Load only with user configs and a valid index
    wire idx_in_range = cfg_index_r < NUM_GPIO'(rscs_pkg::MAX_CFG);
    wire want_load    = otp_has_user_cfg & idx_in_range;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rscs_pkg::ST_HOLD: begin
                if (mr_rise) begin
                    state_nxt = rscs_pkg::ST_CAPT;
                end
            end
            rscs_pkg::ST_CAPT: begin
                state_nxt = want_load ? rscs_pkg::ST_LOAD : rscs_pkg::ST_CAL;
            end
            rscs_pkg::ST_LOAD: begin
                if (boot_sts.load_done) begin
                    state_nxt = rscs_pkg::ST_CHK;
                end
            end
            rscs_pkg::ST_CHK: begin
                state_nxt = rscs_pkg::ST_CAL;
            end
            rscs_pkg::ST_CAL: begin
                if (boot_sts.cal_done) begin
                    state_nxt = rscs_pkg::ST_LOCK;
                end
            end
            rscs_pkg::ST_LOCK: begin
                if (boot_sts.locked) begin
                    state_nxt = rscs_pkg::ST_RUN;
                end
            end
            rscs_pkg::ST_RUN: begin
                state_nxt = rscs_pkg::ST_RUN;
            end
            default: begin
                state_nxt = rscs_pkg::ST_HOLD;
            end
        endcase
        // New master reset returns the sequencer to ST_HOLD
        if (!master_reset_low) begin
            state_nxt = rscs_pkg::ST_HOLD;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_r <= rscs_pkg::ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // (R18) Sequencer outputs, registered
    wire in_hold = state_nxt == rscs_pkg::ST_HOLD;
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            otp_load_req_r  <= 1'b0;
            regulators_en_r <= 1'b0;
            int_clocks_en_r <= 1'b0;
            pll_cal_start_r <= 1'b0;
            pll_lock_en_r   <= 1'b0;
            boot_done_r     <= 1'b0;
        end else begin
            otp_load_req_r  <= state_nxt == rscs_pkg::ST_LOAD;
            regulators_en_r <= !in_hold;
            int_clocks_en_r <= !in_hold;
            pll_cal_start_r <= state_nxt == rscs_pkg::ST_CAL;
            pll_lock_en_r   <= state_nxt == rscs_pkg::ST_LOCK
                            || state_nxt == rscs_pkg::ST_RUN;
            boot_done_r     <= state_nxt == rscs_pkg::ST_RUN;
        end
    end

    // (R19) Failed checksum leaves defaults in place
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            regs_use_defaults_r <= 1'b1;
        end else if (mr_rise) begin
            regs_use_defaults_r <= 1'b1;
        end else if (state_r == rscs_pkg::ST_CHK) begin
            regs_use_defaults_r <= ~boot_sts.cksum_ok;
        end
    end

    // (R17) Defaults: clocks off, pins inputs; (R16) host may change
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            clk_out_en_r    <= {NUM_OUT{rscs_pkg::RST_CLK_EN}};
            gpio_out_mode_r <= {NUM_GPIO{rscs_pkg::RST_GPIO_OUT}};
        end else if (!master_reset_low) begin
            clk_out_en_r    <= {NUM_OUT{rscs_pkg::RST_CLK_EN}};
            gpio_out_mode_r <= {NUM_GPIO{rscs_pkg::RST_GPIO_OUT}};
        end else begin
            if (hw_clken) begin
                clk_out_en_r <= hw_data_o;
            end
            if (hw_gpio) begin
                gpio_out_mode_r <= hw_data_g;
            end
        end
    end

    // Assertions
    a_proto_capture: assert property ( // (R2)
        @(posedge clk) disable iff (!rst_n_s)
        mr_rise |=> serial_is_i2c_r == $past(gpio_in[rscs_pkg::PROTO_PIN]))
        else $error("protocol strap not captured");

    a_default_index: assert property ( // (R4)
        @(posedge clk) disable iff (!rst_n_s)
        (mr_rise && sel_pin_mask == '0)
        |=> cfg_index_r == NUM_GPIO'($past(gpio_in[3:0])))
        else $error("default select index wrong");

    a_index_lsb: assert property ( // (R6)
        @(posedge clk) disable iff (!rst_n_s)
        (mr_rise && sel_pin_mask != '0)
        |=> cfg_index_r[0] == $past(gpio_in[$clog2(NUM_GPIO)'($countones(
            (sel_pin_mask & ~(sel_pin_mask - 1'b1)) - 1'b1))]))
        else $error("select LSB not lowest pin");

    a_ee_or: assert property ( // (R12)
        @(posedge clk) disable iff (!rst_n_s)
        mr_rise |=> ee_search_en_r == !$past(|(gpio_in & ee_dis_pin_mask)))
        else $error("EEPROM disable not ORed");

    a_addr_spi: assert property ( // (R15)
        @(posedge clk) disable iff (!rst_n_s)
        (mr_rise && !gpio_in[rscs_pkg::PROTO_PIN]) |=> !slave_addr_bit_two_r)
        else $error("address bit set in SPI mode");

    a_strap_hold: assert property ( // (R21)
        @(posedge clk) disable iff (!rst_n_s)
        (!mr_rise && !host_wr.valid) |=> $stable(serial_is_i2c_r)
            && $stable(cfg_index_r) && $stable(ee_search_en_r))
        else $error("strap value changed without cause");

    a_no_load_user: assert property ( // (R9)
        @(posedge clk) disable iff (!rst_n_s)
        !otp_has_user_cfg && state_r == rscs_pkg::ST_CAPT
        |=> !otp_load_req_r ##1 !otp_load_req_r)
        else $error("load requested without user configs");

    a_cksum_defaults: assert property ( // (R19)
        @(posedge clk) disable iff (!rst_n_s)
        (state_r == rscs_pkg::ST_CHK && !boot_sts.cksum_ok && master_reset_low)
        |=> regs_use_defaults_r)
        else $error("bad checksum did not keep defaults");

    a_defaults_off: assert property ( // (R17)
        @(posedge clk) disable iff (!rst_n_s)
        !master_reset_low ##1 !master_reset_low
        |-> clk_out_en_r == '0 && gpio_out_mode_r == '0)
        else $error("outputs not default in reset");

    a_host_write: assert property ( // (R16)
        @(posedge clk) disable iff (!rst_n_s)
        (hw_index && !mr_rise) |=> cfg_index_r == $past(hw_data_g))
        else $error("host write to index lost");

endmodule // rscs_strap_cfg

// [dv/rscs_board.sv]
// Board strap resistors and boot status responder model
`timescale 1ns/1ps
module rscs_board (
    input  wire logic                 clk,
    input  wire logic [15:0]          drive_en,
    input  wire logic [15:0]          drive_val,
    input  wire logic [3:0]           dly,
    input  wire logic                 cksum_good,
    input  wire logic                 otp_load_req_r,
    input  wire logic                 pll_cal_start_r,
    input  wire logic                 pll_lock_en_r,
    output logic [15:0]               gpio_in,
    output rscs_pkg::rscs_boot_sts_s  boot_sts
);
    logic [2:0] req;
    logic [2:0] req_q = 3'h0;
    logic [7:0] cnt_r = 8'h00;
    logic       ready;

    assign req   = {otp_load_req_r, pll_cal_start_r, pll_lock_en_r};
    assign ready = (req == req_q) && (cnt_r >= {4'h0, dly});
    assign gpio_in = (drive_val & drive_en) | ~drive_en | 16'h0100;
    // Done flags drop with the request, so a stale level cannot pass
    assign boot_sts.load_done = req[2] & ready;
    assign boot_sts.cksum_ok  = cksum_good;
    assign boot_sts.cal_done  = req[1] & ready;
    assign boot_sts.locked    = req[0] & ready;

    always_ff @(posedge clk) begin
        req_q <= req;
        cnt_r <= (req != req_q) ? 8'h00 : cnt_r + 8'h01;
    end
endmodule // rscs_board

// [dv/reset_strap_config_select_tb.sv]
// Self-checking bench for the reset strap configuration block
`timescale 1ns/1ps
module reset_strap_config_select_tb;
    typedef struct packed {
        logic        i2c;
        logic [15:0] idx;
        logic        ee;
        logic        abit;
        logic        dflt;
        logic        ld;
    } rscs_exp_s;
    typedef struct packed {
        logic        i2c;
        logic [15:0] idx;
        logic        ee;
        logic        abit;
        logic [15:0] clk_en;
        logic [15:0] gpio;
    } rscs_hexp_s;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic master_reset_low = 1'b0;
    logic [15:0] sel_pin_mask = '0, ee_dis_pin_mask = '0, addr_pin_mask = '0;
    logic [15:0] drive_en = '0, drive_val = '0, gpio_in, pins;
    logic otp_has_user_cfg = 1'b0, cksum_good = 1'b0;
    logic [3:0] dly = 4'h0;
    rscs_pkg::rscs_boot_sts_s boot_sts;
    rscs_pkg::rscs_host_wr_s  host_wr = '0;
    logic serial_is_i2c_r, ee_search_en_r, slave_addr_bit_two_r, hold_fault_r;
    logic otp_load_req_r, regs_use_defaults_r, regulators_en_r, int_clocks_en_r;
    logic pll_cal_start_r, pll_lock_en_r, boot_done_r, done_q, ld_seen;
    logic [15:0] cfg_index_r, clk_out_en_r, gpio_out_mode_r;
    logic [15:0] lfsr = 16'h0005;
    int n_mismatch = 0;
    int compares = 0;
    rscs_exp_s  bq[$];
    rscs_hexp_s hq[$];
    rscs_exp_s  e;
    rscs_hexp_s h;
    // Case table: select, disable, address masks, forced high, forced low
    logic [15:0] t_sel[6] = '{16'h0000, 16'h0164, 16'h0090, 16'h801e, 16'h0000, 16'h0000};
    logic [15:0] t_ee[6]  = '{16'h0000, 16'h0c00, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    logic [15:0] t_ad[6]  = '{16'h0000, 16'h00a0, 16'h0020, 16'h0000, 16'h8001, 16'h0000};
    logic [15:0] t_hi[6]  = '{16'h0000, 16'h0600, 16'h0020, 16'h8000, 16'h0000, 16'h0000};
    logic [15:0] t_lo[6]  = '{16'h0000, 16'h0800, 16'h0200, 16'h0000, 16'h0000, 16'h0000};
    logic [5:0]  t_otp = 6'h2f;
    logic [5:0]  t_cks = 6'h3b;

    always #20 clk = ~clk;

    rscs_strap_cfg #(.NUM_GPIO(16), .NUM_OUT(16)) i_dut (
        .clk(clk), .reset_n(reset_n), .master_reset_low(master_reset_low),
        .gpio_in(gpio_in), .sel_pin_mask(sel_pin_mask), .ee_dis_pin_mask(ee_dis_pin_mask),
        .addr_pin_mask(addr_pin_mask), .otp_has_user_cfg(otp_has_user_cfg),
        .boot_sts(boot_sts), .host_wr(host_wr), .serial_is_i2c_r(serial_is_i2c_r),
        .cfg_index_r(cfg_index_r), .ee_search_en_r(ee_search_en_r),
        .slave_addr_bit_two_r(slave_addr_bit_two_r), .hold_fault_r(hold_fault_r),
        .otp_load_req_r(otp_load_req_r), .regs_use_defaults_r(regs_use_defaults_r),
        .clk_out_en_r(clk_out_en_r), .gpio_out_mode_r(gpio_out_mode_r),
        .regulators_en_r(regulators_en_r), .int_clocks_en_r(int_clocks_en_r),
        .pll_cal_start_r(pll_cal_start_r), .pll_lock_en_r(pll_lock_en_r),
        .boot_done_r(boot_done_r));

    rscs_board i_board (
        .clk(clk), .drive_en(drive_en), .drive_val(drive_val), .dly(dly),
        .cksum_good(cksum_good), .otp_load_req_r(otp_load_req_r),
        .pll_cal_start_r(pll_cal_start_r), .pll_lock_en_r(pll_lock_en_r),
        .gpio_in(gpio_in), .boot_sts(boot_sts));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Assigned pins packed lowest first; empty mask means pins 3..0
    function automatic logic [15:0] pack_idx(input logic [15:0] p, input logic [15:0] m);
        logic [15:0] r;
        int k;
        r = '0;
        k = 0;
        if (m == 16'h0000) return {12'h000, p[3:0]};
        for (int i = 0; i < 16; i++) if (m[i]) begin
            r[k] = p[i];
            k++;
        end
        return r;
    endfunction

    task automatic chk(input logic [31:0] a, input logic [31:0] x, input string m);
        compares++;
        if (a !== x) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, a, x);
        end
    endtask

    task automatic cmp_boot(input rscs_exp_s x);
        chk(32'(serial_is_i2c_r), 32'(x.i2c), "protocol");
        chk(32'(cfg_index_r), 32'(x.idx), "index");
        chk(32'(ee_search_en_r), 32'(x.ee), "eeprom search");
        chk(32'(slave_addr_bit_two_r), 32'(x.abit), "address bit");
        chk(32'(regs_use_defaults_r), 32'(x.dflt), "defaults");
        chk(32'(ld_seen), 32'(x.ld), "load request");
        chk({clk_out_en_r, gpio_out_mode_r}, 32'h0, "outputs off");
        chk(32'({regulators_en_r, int_clocks_en_r, pll_lock_en_r, hold_fault_r}),
            32'h0000000e, "bring-up");
    endtask

    task automatic cmp_host(input rscs_hexp_s x);
        chk(32'(serial_is_i2c_r), 32'(x.i2c), "host protocol");
        chk(32'(cfg_index_r), 32'(x.idx), "host index");
        chk(32'(ee_search_en_r), 32'(x.ee), "host eeprom search");
        chk(32'(slave_addr_bit_two_r), 32'(x.abit), "host address bit");
        chk(32'(clk_out_en_r), 32'(x.clk_en), "host clock enable");
        chk(32'(gpio_out_mode_r), 32'(x.gpio), "host pin mode");
    endtask

    task automatic print_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Monitor: results are settled 1 ns after the edge
    initial begin
        done_q = 1'b0;
        ld_seen = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            // Load request is a level inside the boot, gone by its end
            if (otp_load_req_r === 1'b1) ld_seen = 1'b1;
            if (boot_done_r === 1'b1 && done_q !== 1'b1) begin
                if (bq.size() == 0) chk(32'h1, 32'h0, "unexpected boot");
                else cmp_boot(bq.pop_front());
                ld_seen = 1'b0;
            end
            if (host_wr.valid === 1'b1) begin
                if (hq.size() == 0) chk(32'h1, 32'h0, "unexpected write");
                else cmp_host(hq.pop_front());
            end
            done_q = boot_done_r;
        end
    end

    task automatic host_write(input logic [2:0] f, input logic [15:0] d);
        @(posedge clk);
        #2;
        host_wr = {1'b1, f, d};
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #2 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        h.i2c = rscs_pkg::RST_I2C;
        h.idx = 16'hffff;
        h.ee = ~rscs_pkg::RST_EE_DIS;
        h.abit = rscs_pkg::RST_ADDR_BIT;
        h.clk_en = '0;
        h.gpio = '0;
        for (int i = 0; i < 6; i++) begin
            #2;
            master_reset_low = 1'b0;
            sel_pin_mask = t_sel[i];
            ee_dis_pin_mask = t_ee[i];
            addr_pin_mask = t_ad[i];
            otp_has_user_cfg = t_otp[i];
            cksum_good = t_cks[i];
            dly = 4'(i);
            lfsr = lfsr_next(lfsr);
            drive_en = (i == 0) ? 16'h0000 : 16'hffff;
            drive_val = (lfsr | t_hi[i]) & ~t_lo[i];
            @(posedge clk);
            // Clock enable write in reset is refused; outputs already forced off
            h.clk_en = '0;
            h.gpio = '0;
            hq.push_back(h);
            host_write(rscs_pkg::FLD_CLK_EN, 16'hffff);
            @(posedge clk);
            #2 host_wr = '0;
            master_reset_low = 1'b1;
            pins = (drive_val & drive_en) | ~drive_en | 16'h0100;
            e.i2c = pins[9];
            e.idx = pack_idx(pins, sel_pin_mask);
            e.ee = ~|(pins & ee_dis_pin_mask);
            e.abit = 1'b0;
            for (int k = 0; k < 16; k++) if (addr_pin_mask[k]) e.abit = pins[k];
            e.abit = e.abit & pins[9];
            e.ld = otp_has_user_cfg && e.idx < 16;
            e.dflt = !(e.ld && cksum_good);
            bq.push_back(e);
            @(posedge clk);
            // Pins move after capture; outputs must not follow
            #2 drive_val = ~drive_val;
            for (int n = 0; n < 200 && boot_done_r !== 1'b1; n++) @(posedge clk);
            lfsr = lfsr_next(lfsr);
            h.i2c = ~e.i2c;
            h.idx = e.idx;
            h.ee = e.ee;
            h.abit = e.abit;
            hq.push_back(h);
            host_write(rscs_pkg::FLD_PROTO, {15'h0000, ~e.i2c});
            h.clk_en = lfsr;
            hq.push_back(h);
            host_write(rscs_pkg::FLD_CLK_EN, lfsr);
            h.gpio = ~lfsr;
            hq.push_back(h);
            host_write(rscs_pkg::FLD_GPIO, ~lfsr);
            h.idx = {lfsr[7:0], lfsr[15:8]};
            hq.push_back(h);
            host_write(rscs_pkg::FLD_INDEX, {lfsr[7:0], lfsr[15:8]});
            h.ee = ~lfsr[4];
            hq.push_back(h);
            host_write(rscs_pkg::FLD_EE_DIS, {15'h0000, lfsr[4]});
            h.abit = lfsr[5];
            hq.push_back(h);
            host_write(rscs_pkg::FLD_ADDR, {15'h0000, lfsr[5]});
            // Unknown field code must leave every setting alone
            hq.push_back(h);
            host_write(3'h6, 16'hffff);
            @(posedge clk);
            #2 host_wr = '0;
            repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        chk(32'(bq.size() + hq.size()), 32'h0, "results missing");
        print_verdict();
    end

    // Watchdog: six boots need well under 2500 cycles
    initial begin
        #100000;
        n_mismatch++;
        $display("wrong value at %0t: run timed out", $time);
        print_verdict();
    end
endmodule // reset_strap_config_select_tb
